// ### rtl/scap_pkg.sv
package scap_pkg;

	// ------------------------------------------------------------
	// Sizes and timing
	// ------------------------------------------------------------
	localparam int NUM_MACS = 8;
	localparam int SYNC_STAGES = 2;
	localparam int STRAP_HOLD_CYCLES = 10;
	localparam int SAMPLE_CNT = STRAP_HOLD_CYCLES - SYNC_STAGES;
	localparam int CNT_W = 4;
	localparam int STRAP_W = 4 + NUM_MACS;

	// ------------------------------------------------------------
	// Strap bit positions in the synchronised word
	// ------------------------------------------------------------
	localparam int SY_RATE_LSB = 0;
	localparam int SY_RX_BIT = 2;
	localparam int SY_TX_BIT = 3;
	localparam int SY_WIDTH_LSB = 4;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_MAC_BASE = 8'h20;
	localparam logic [7:0] ADR_MAC_LAST = 8'h3C;
	localparam int MAC_IDX_LSB = 2;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_SELF_RST_BIT = 0;
	localparam int CTRL_TEST_BIT = 1;
	localparam int CTRL_TRATE_LSB = 2;
	localparam int MAC_RATE_LSB = 0;
	localparam int MAC_WIDTH_BIT = 2;
	localparam int MAC_RXREV_BIT = 3;
	localparam int MAC_TXREV_BIT = 4;
	localparam int MAC_UNUSABLE_BIT = 5;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_RATE_LSB = 1;
	localparam int STAT_ILLEGAL_BIT = 3;
	localparam int STAT_RX_BIT = 4;
	localparam int STAT_TX_BIT = 5;
	localparam int STAT_WIDTH_LSB = 8;

	// ------------------------------------------------------------
	// Encodings and reset values
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RATE_1G25 = 2'b00,
		RATE_2G5 = 2'b01,
		RATE_3G125 = 2'b10,
		RATE_ILLEGAL = 2'b11
	} scap_rate_t;

	typedef enum logic [0:0] {
		ST_HOLD = 1'b0,
		ST_RUN = 1'b1
	} scap_state_t;

	localparam logic [1:0] RATE_RST = RATE_3G125;
	localparam logic [1:0] TRATE_RST = 2'h0;
	localparam logic [NUM_MACS-1:0] WIDTH_RST = 8'h00;
	localparam logic [31:0] DAT_RST = 32'h0000_0000;

	typedef struct packed {
		scap_state_t st;
		logic [CNT_W-1:0] cnt;
		logic done;
		logic [1:0] cap_rate;
		logic cap_rx;
		logic cap_tx;
		logic [NUM_MACS-1:0] cap_width;
		logic [NUM_MACS-1:0][1:0] rate;
		logic [NUM_MACS-1:0] width_1x;
		logic [NUM_MACS-1:0] rx_rev;
		logic [NUM_MACS-1:0] tx_rev;
		logic test_mode;
		logic [1:0] test_rate;
		logic rate_oe;
		logic [1:0] rate_o;
		logic ack;
		logic [31:0] dat;
	} scap_regs_t;

endpackage

// ### rtl/scap_sync_if.sv
`timescale 1ns/1ps
interface scap_sync_if;
	import scap_pkg::*;

	// Raw strap pins and their synchronised copy
	logic [STRAP_W-1:0] raw;
	logic [STRAP_W-1:0] sync;

	modport src (output raw, input sync);
	modport snk (input raw, output sync);
endinterface

// ### rtl/scap_sync.sv
`timescale 1ns/1ps
module scap_sync
	import scap_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	scap_sync_if.snk sif
);

	typedef struct packed {
		logic [STRAP_W-1:0] s1;
		logic [STRAP_W-1:0] s2;
	} scap_sync_t;

	scap_sync_t sy_reg;
	scap_sync_t sy_next;

	// Two-stage chain; first stage feeds only the second
	always_comb
	begin
		sy_next = sy_reg;
		sy_next.s1 = sif.raw;
		sy_next.s2 = sy_reg.s1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sy_reg <= '0;
		else
			sy_reg <= sy_next;
	end

	assign sif.sync = sy_reg.s2;

endmodule

// ### rtl/scap_top.sv
`timescale 1ns/1ps
module scap_top
	import scap_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_STB_I,
	input wire logic WB_CYC_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [1:0] PORT_RATE_STRAP_I,
	output logic [1:0] PORT_RATE_STRAP_O,
	output logic PORT_RATE_STRAP_OE,
	input wire logic RX_LANE_REVERSE_STRAP,
	input wire logic TX_LANE_REVERSE_STRAP,
	input wire logic [NUM_MACS-1:0] PORT_WIDTH_SELECT,
	output logic [2*NUM_MACS-1:0] PORT_RATE,
	output logic [NUM_MACS-1:0] PORT_WIDTH_1X,
	output logic [NUM_MACS-1:0] RX_LANE_REVERSE,
	output logic [NUM_MACS-1:0] TX_LANE_REVERSE,
	output logic CAPTURE_DONE
);

	// ------------------------------------------------------------
	// Strap synchroniser
	// ------------------------------------------------------------
	scap_sync_if sif ();

	// Pins enter the clock domain through two flops
	assign sif.raw = {PORT_WIDTH_SELECT, TX_LANE_REVERSE_STRAP,
		RX_LANE_REVERSE_STRAP, PORT_RATE_STRAP_I};

	scap_sync u_sync (
		.clk(CORE_CLK),
		.rst_n(RST_B),
		.sif(sif)
	);

	// ------------------------------------------------------------
	// Address decode helpers
	// ------------------------------------------------------------
	function automatic logic is_mac(input logic [7:0] a);
		is_mac = (a >= ADR_MAC_BASE) && (a <= ADR_MAC_LAST) &&
			(a[1:0] == 2'b00);
	endfunction

	function automatic logic [2:0] mac_idx(input logic [7:0] a);
		mac_idx = a[MAC_IDX_LSB +: 3];
	endfunction

	// Read word for one address; unmapped reads give zero
	function automatic logic [31:0] rd_word(input scap_regs_t s,
		input logic [7:0] a);
		logic [2:0] i;
		rd_word = DAT_RST;
		i = mac_idx(a);
		if (a == ADR_CTRL)
		begin
			rd_word[CTRL_TEST_BIT] = s.test_mode;
			rd_word[CTRL_TRATE_LSB +: 2] = s.test_rate;
		end
		else if (a == ADR_STATUS)
		begin
			rd_word[STAT_DONE_BIT] = s.done;
			rd_word[STAT_RATE_LSB +: 2] = s.cap_rate;
			rd_word[STAT_ILLEGAL_BIT] = (s.cap_rate == RATE_ILLEGAL);
			rd_word[STAT_RX_BIT] = s.cap_rx;
			rd_word[STAT_TX_BIT] = s.cap_tx;
			rd_word[STAT_WIDTH_LSB +: NUM_MACS] = s.cap_width;
		end
		else if (is_mac(a))
		begin
			rd_word[MAC_RATE_LSB +: 2] = s.rate[i];
			rd_word[MAC_WIDTH_BIT] = s.width_1x[i];
			rd_word[MAC_RXREV_BIT] = s.rx_rev[i];
			rd_word[MAC_TXREV_BIT] = s.tx_rev[i];
			rd_word[MAC_UNUSABLE_BIT] = s.width_1x[i] &
				(s.cap_rx | s.cap_tx);
		end
	endfunction

	// ------------------------------------------------------------
	// State and next-state logic
	// ------------------------------------------------------------
	scap_regs_t st_reg;
	scap_regs_t st_next;
	logic req;
	logic wr0;
	logic self_rst;

	// Bus request, byte-0 write and self-reset strobe
	assign req = WB_CYC_I & WB_STB_I & ~st_reg.ack;
	assign wr0 = req & WB_WE_I & WB_SEL_I[0];
	assign self_rst = wr0 & (WB_ADR_I == ADR_CTRL) &
		WB_DAT_I[CTRL_SELF_RST_BIT];

	always_comb
	begin
		st_next = st_reg;
		st_next.ack = 1'b0;

		// Capture sequence: wait out the hold window, then latch
		unique case (st_reg.st)
			ST_HOLD:
			begin
				if (st_reg.cnt == SAMPLE_CNT[CNT_W-1:0])
				begin
					st_next.st = ST_RUN;
					st_next.done = 1'b1;
					st_next.cap_rate = sif.sync[SY_RATE_LSB +: 2];
					st_next.cap_rx = sif.sync[SY_RX_BIT];
					st_next.cap_tx = sif.sync[SY_TX_BIT];
					st_next.cap_width = sif.sync[SY_WIDTH_LSB +: NUM_MACS];
					for (int i = 0; i < NUM_MACS; i++)
						st_next.rate[i] = sif.sync[SY_RATE_LSB +: 2];
					st_next.width_1x =
						sif.sync[SY_WIDTH_LSB +: NUM_MACS];
				end
				else
					st_next.cnt = st_reg.cnt + 1'b1;
			end
			ST_RUN:
				st_next.st = ST_RUN; // Straps no longer looked at
		endcase

		// Register bus: latch read data, apply write, ack next cycle
		if (req)
		begin
			st_next.ack = 1'b1;
			st_next.dat = rd_word(st_reg, WB_ADR_I);
		end
		if (wr0 && (WB_ADR_I == ADR_CTRL))
		begin
			st_next.test_mode = WB_DAT_I[CTRL_TEST_BIT];
			st_next.test_rate = WB_DAT_I[CTRL_TRATE_LSB +: 2];
		end
		if (wr0 && is_mac(WB_ADR_I))
		begin
			st_next.rate[mac_idx(WB_ADR_I)] =
				WB_DAT_I[MAC_RATE_LSB +: 2];
			st_next.width_1x[mac_idx(WB_ADR_I)] =
				WB_DAT_I[MAC_WIDTH_BIT];
		end

		// Self-reset re-arms the capture window
		if (self_rst)
		begin
			st_next.st = ST_HOLD;
			st_next.cnt = '0;
			st_next.done = 1'b0;
			st_next.test_mode = 1'b0;
		end

		// Effective lane order; 1x ports never reverse
		st_next.rx_rev = {NUM_MACS{st_next.cap_rx}} &
			~st_next.width_1x;
		st_next.tx_rev = {NUM_MACS{st_next.cap_tx}} &
			~st_next.width_1x;

		// Rate pins driven only in test mode after capture
		st_next.rate_oe = st_next.test_mode & st_next.done;
		st_next.rate_o = st_next.test_rate;
	end

	// State register, reset by the hard reset pin; cap_rate and the MAC rate fields load RATE_3G125, the rest (test_rate included) clear
	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			st_reg <= '0;
			st_reg.st <= ST_HOLD;
			st_reg.cap_rate <= RATE_RST;
			st_reg.rate <= {NUM_MACS{RATE_RST}};
			st_reg.width_1x <= WIDTH_RST;
			st_reg.test_rate <= TRATE_RST;
			st_reg.dat <= DAT_RST;
		end
		else
			st_reg <= st_next;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign WB_DAT_O = st_reg.dat;
	assign WB_ACK_O = st_reg.ack;
	assign PORT_RATE_STRAP_O = st_reg.rate_o;
	assign PORT_RATE_STRAP_OE = st_reg.rate_oe;
	assign PORT_RATE = st_reg.rate;
	assign PORT_WIDTH_1X = st_reg.width_1x;
	assign RX_LANE_REVERSE = st_reg.rx_rev;
	assign TX_LANE_REVERSE = st_reg.tx_rev;
	assign CAPTURE_DONE = st_reg.done;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	sequence s_self_rst;
		self_rst;
	endsequence

	sequence s_mac0_wr;
		wr0 && (WB_ADR_I == ADR_MAC_BASE);
	endsequence

	// Capture point and read-back requests
	sequence s_capture;
		st_reg.st == ST_HOLD && st_reg.cnt == SAMPLE_CNT[CNT_W-1:0] &&
			!self_rst;
	endsequence

	sequence s_status_rd;
		req && !WB_WE_I && (WB_ADR_I == ADR_STATUS);
	endsequence

	sequence s_unmapped_rd;
		req && !WB_WE_I && (WB_ADR_I != ADR_CTRL) &&
			(WB_ADR_I != ADR_STATUS) && !is_mac(WB_ADR_I);
	endsequence

	rate_load_a: assert property ($rose(CAPTURE_DONE) |->
		PORT_RATE[1:0] == st_reg.cap_rate &&
		st_reg.cap_rate == $past(sif.sync[1:0]))
		else $error("captured rate not loaded into MAC field");

	width_load_a: assert property ($rose(CAPTURE_DONE) |->
		PORT_WIDTH_1X == $past(sif.sync[SY_WIDTH_LSB +: NUM_MACS]))
		else $error("width strap not loaded");

	strap_hold_a: assert property (CAPTURE_DONE &&
		$past(CAPTURE_DONE) |-> $stable(st_reg.cap_rate) &&
		$stable(st_reg.cap_rx) && $stable(st_reg.cap_tx))
		else $error("captured straps changed after reset");

	self_reset_a: assert property (s_self_rst |=>
		!CAPTURE_DONE [*8] ##1 !CAPTURE_DONE ##1 CAPTURE_DONE)
		else $error("self reset capture timing wrong");

	sw_override_a: assert property (s_mac0_wr |=>
		PORT_RATE[1:0] == $past(WB_DAT_I[1:0]))
		else $error("software rate override lost");

	rx_order_a: assert property (CAPTURE_DONE |->
		RX_LANE_REVERSE == ({NUM_MACS{st_reg.cap_rx}} & ~PORT_WIDTH_1X))
		else $error("receive lane order wrong");

	tx_order_a: assert property (CAPTURE_DONE |->
		TX_LANE_REVERSE == ({NUM_MACS{st_reg.cap_tx}} & ~PORT_WIDTH_1X))
		else $error("transmit lane order wrong");

	test_drive_a: assert property (PORT_RATE_STRAP_OE |->
		st_reg.test_mode && CAPTURE_DONE)
		else $error("rate pins driven outside test mode");

	ack_pulse_a: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("bus ack not a single cycle");

	// Capture point, self-reset clear and read-back checks
	strap_capture_a: assert property (s_capture |=>
		CAPTURE_DONE && st_reg.cap_rx == $past(sif.sync[SY_RX_BIT]) &&
		st_reg.cap_tx == $past(sif.sync[SY_TX_BIT]))
		else $error("straps not captured at end of hold window");

	count_range_a: assert property (st_reg.st == ST_HOLD |->
		st_reg.cnt <= SAMPLE_CNT[CNT_W-1:0])
		else $error("hold counter ran past sample point");

	self_clear_a: assert property (s_self_rst |=>
		!CAPTURE_DONE && !PORT_RATE_STRAP_OE)
		else $error("self reset left capture or pin drive active");

	illegal_flag_a: assert property (s_status_rd |=>
		WB_DAT_O[STAT_ILLEGAL_BIT] ==
		(WB_DAT_O[STAT_RATE_LSB +: 2] == RATE_ILLEGAL))
		else $error("illegal rate code not flagged");

	unmapped_rd_a: assert property (s_unmapped_rd |=>
		WB_DAT_O == DAT_RST)
		else $error("unmapped read returned data");

endmodule

// ### bench/scap_strap_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Board strap resistors
// ------------------------------------------------------------
module scap_strap_model
	import scap_pkg::*;
(
	input wire logic [1:0] rate_set,
	input wire logic rx_set,
	input wire logic tx_set,
	input wire logic [NUM_MACS-1:0] width_set,
	input wire logic [1:0] rate_drv,
	input wire logic rate_oe,
	output logic [1:0] rate_pin,
	output logic rx_pin,
	output logic tx_pin,
	output logic [NUM_MACS-1:0] width_pin
);
	// Straps sit still while the bench holds them; device wins in test mode
	assign rate_pin = rate_oe ? rate_drv : rate_set;
	assign rx_pin = rx_set;
	assign tx_pin = tx_set;
	assign width_pin = width_set;
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import scap_pkg::*;
	logic clk = 0, rst_b = 0, we = 0, stb = 0, cyc = 0;
	logic [7:0] adr = '0;
	logic [31:0] dat = '0, dout;
	logic [3:0] sel = '0;
	logic ack, oe, done, rxs = 0, txs = 0, e_rx, e_tx, rx_p, tx_p;
	logic [1:0] rs = 2'b10, ro, rate_p, e_rate;
	logic [NUM_MACS-1:0] ws = '0, e_w, w1x, rxr, txr, w_p;
	logic [2*NUM_MACS-1:0] prate;
	int failures = 0, cmp_count = 0, seed;

	// ------------------------------------------------------------
	// Clock, partner and device
	// ------------------------------------------------------------
	always #10 clk = ~clk;
	scap_strap_model STRAPS (.rate_set(rs), .rx_set(rxs), .tx_set(txs),
		.width_set(ws), .rate_drv(ro), .rate_oe(oe), .rate_pin(rate_p),
		.rx_pin(rx_p), .tx_pin(tx_p), .width_pin(w_p));
	scap_top DUT (.CORE_CLK(clk), .RST_B(rst_b), .WB_ADR_I(adr),
		.WB_DAT_I(dat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_STB_I(stb),
		.WB_CYC_I(cyc), .WB_DAT_O(dout), .WB_ACK_O(ack),
		.PORT_RATE_STRAP_I(rate_p), .PORT_RATE_STRAP_O(ro),
		.PORT_RATE_STRAP_OE(oe), .RX_LANE_REVERSE_STRAP(rx_p),
		.TX_LANE_REVERSE_STRAP(tx_p), .PORT_WIDTH_SELECT(w_p),
		.PORT_RATE(prate), .PORT_WIDTH_1X(w1x), .RX_LANE_REVERSE(rxr),
		.TX_LANE_REVERSE(txr), .CAPTURE_DONE(done));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'h1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			failures++;
			$display("[ERR] %0t bus request not acknowledged", $time);
		end
		q = dout;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		@(posedge clk);
	endtask

	task automatic wait_done();
		int n;
		for (n = 0; n < 20 && done !== 1'b1; n++)
			@(posedge clk);
		if (done !== 1'b1)
			failures++;
	endtask

	task automatic latch_exp();
		e_rate = rs;
		e_rx = rxs;
		e_tx = txs;
		e_w = ws;
	endtask

	function automatic logic [31:0] mac_exp(input int i);
		return {26'h0, e_w[i] & (e_rx | e_tx), e_tx & ~e_w[i],
			e_rx & ~e_w[i], e_w[i], e_rate};
	endfunction

	// Outputs and registers against what the straps asked for
	task automatic verify();
		logic [31:0] q;
		chk(done, 1);
		chk(prate, {NUM_MACS{e_rate}});
		chk(w1x, e_w);
		chk(rxr, {NUM_MACS{e_rx}} & ~e_w);
		chk(txr, {NUM_MACS{e_tx}} & ~e_w);
		wb(0, ADR_STATUS, 0, q);
		chk(q, {16'h0, e_w, 2'b00, e_tx, e_rx, &e_rate, e_rate, 1'b1});
		for (int i = 0; i < NUM_MACS; i++)
		begin
			wb(0, ADR_MAC_BASE + 8'(i << MAC_IDX_LSB), 0, q);
			chk(q, mac_exp(i));
		end
	endtask

	task automatic hard_reset();
		@(posedge clk);
		rst_b <= 0;
		repeat (5) @(posedge clk);
		chk(prate, 16'hAAAA);
		chk(done, 0);
		latch_exp();
		rst_b <= 1;
		wait_done();
		verify();
	endtask

	task automatic wrap_up();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	initial
	begin
		#(20 * 20000);
		failures++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial
	begin
		logic [31:0] q;
		seed = $urandom(63911);
		rxs <= 1;
		txs <= 1;
		hard_reset();
		// Every rate code through self-reset, random lane straps
		for (int k = 0; k < 4; k++)
		begin
			rs <= k[1:0];
			rxs <= 1'($urandom);
			txs <= 1'($urandom);
			ws <= NUM_MACS'($urandom);
			wb(1, ADR_CTRL, 32'h0000_0001, q);
			latch_exp();
			chk(done, 0);
			wait_done();
			verify();
		end
		// Strap changes after capture change nothing
		rs <= ~rs;
		rxs <= ~rxs;
		txs <= ~txs;
		ws <= ~ws;
		repeat (12) @(posedge clk);
		verify();
		// Software override of the MAC 0 rate
		wb(1, ADR_MAC_BASE, {30'h0, ~e_rate}, q);
		wb(0, ADR_MAC_BASE, 0, q);
		chk(q[1:0], 2'(~e_rate));
		chk(prate[1:0], 2'(~e_rate));
		// Rate pins driven only in test mode
		chk(oe, 0);
		wb(1, ADR_CTRL, 32'h0000_0006, q);
		chk({oe, ro, rate_p}, 5'b1_01_01);
		wb(1, ADR_CTRL, 32'h0000_0000, q);
		chk(oe, 0);
		wb(0, 8'h80, 0, q);
		chk(q, 32'h0000_0000);
		// Second hard reset, illegal code kept and flagged
		rs <= 2'b11;
		rxs <= 1;
		txs <= 0;
		ws <= 8'hFF;
		hard_reset();
		wrap_up();
	end
endmodule
